// [include/apt_defines.vh]
`ifndef APT_DEFINES_VH
`define APT_DEFINES_VH
// ----------------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define APT_OFS_CTRL      12'h000
`define APT_OFS_STATUS    12'h004
`define APT_OFS_POWER     12'h008
`define APT_OFS_FILTER    12'h00C
`define APT_OFS_BAND      12'h010
`define APT_OFS_TUNED     12'h014
// ----------------------------------------------------------------------
// control register bits (write-one pulses)
// ----------------------------------------------------------------------
`define APT_CTRL_OPERATE  0
`define APT_CTRL_MANUAL   1
`define APT_CTRL_AUTO     2
`define APT_CTRL_LDN      3
`define APT_CTRL_LUP      4
`define APT_CTRL_CDN      5
`define APT_CTRL_CUP      6
`define APT_CTRL_CCDN     7
`define APT_CTRL_CCUP     8
`define APT_CTRL_MENU     9
// ----------------------------------------------------------------------
// power thresholds in watts, current in amperes
// ----------------------------------------------------------------------
`define APT_WIN_LOW_W     12'h03C
`define APT_WIN_HIGH_W    12'h064
`define APT_TUNE_MAX_W    12'h0FA
`define APT_OVL_LOW_W     12'h41A
`define APT_OVL_MID_W     12'h514
`define APT_OVL_HIGH_W    12'h5DC
`define APT_OVL_CUR_A     8'h2A
// ----------------------------------------------------------------------
// times and derived cycle counts at 40 MHz
// ----------------------------------------------------------------------
`define APT_CLK_HZ        40000000
`define APT_OVL_LOW_MS    500
`define APT_OVL_MID_MS    100
`define APT_OVL_CUR_MS    1000
`define APT_ERR_SHOW_MS   1500
`define APT_MS_CYC(ms)    ((ms) * (`APT_CLK_HZ / 1000))
// ----------------------------------------------------------------------
// display message codes, then element step max and reset values
// ----------------------------------------------------------------------
`define APT_MSG_NONE      4'h0
`define APT_MSG_SETPTT    4'h1
`define APT_MSG_SIGLOW    4'h2
`define APT_MSG_SIGHIGH   4'h3
`define APT_MSG_PLTUNE    4'h4
`define APT_MSG_DONE      4'h5
`define APT_MSG_ABORT     4'h6
`define APT_MSG_INOVL     4'h7
`define APT_MSG_INOVL1    4'h8
`define APT_MSG_OUTOVL    4'h9
`define APT_MSG_OUTMID    4'hA
`define APT_MSG_OUTHIGH   4'hB
`define APT_MSG_CUROVL    4'hC
`define APT_STEP_MAX      8'hFF
`define APT_STEP_RST      8'h80
`endif

// [verilog/apt_amp_ctrl.v]
`timescale 1ns/1ps
`include "apt_defines.vh"

// Functional notes
// - power-on: bypass, ready off, filters frozen
// - operate press toggles active and bypass
// - activation only while transceiver ptt off
// - no bypass while any tuning mode
// - manual tune toggles, needs active amp
// - tuning meter view, show element values
// - below window shows signal low
// - above window shows signal high
// - inside window: please tune, allow steps
// - over 250 W aborts tuning
// - output inductance steps, 255 steps
// - output capacitance steps, 255 steps
// - softkeys step center capacitance setting
// - ptt drop or button ends tuning
// - on finish store settings, mark tuned
// - menu refused during manual tuning
// - active plus ptt routes amplified signal
// - overload drops ptt until release, error shown 1500 ms
// - software and hardware input overload distinct
// - 1050 W over 500 ms flags
// - 1300 W over 100 ms flags
// - 1500 W instant trip; 42 A 1000 ms
module apt_amp_ctrl #(
    parameter integer SUBBANDS = 64,                          // stored subband slots
    parameter integer LOW_CYC  = `APT_MS_CYC(`APT_OVL_LOW_MS), // 1050 W persistence
    parameter integer MID_CYC  = `APT_MS_CYC(`APT_OVL_MID_MS), // 1300 W persistence
    parameter integer CUR_CYC  = `APT_MS_CYC(`APT_OVL_CUR_MS), // 42 A persistence
    parameter integer ERR_CYC  = `APT_MS_CYC(`APT_ERR_SHOW_MS) // error message time
) (
    input  wire        clk_sys,    // 40 MHz system clock
    input  wire        rst,        // async reset, active high
    input  wire        psel,       // apb select
    input  wire        penable,    // apb access phase
    input  wire        pwrite,     // apb direction
    input  wire [11:0] paddr,      // apb byte address
    input  wire [31:0] pwdata,     // apb write data
    output reg  [31:0] prdata,     // apb read data
    output reg         pready,     // apb ready
    output reg         pslverr,    // apb error
    input  wire        trxPtt,     // transceiver ptt pin, active high
    input  wire        inOvlSw,    // input overload from software path
    input  wire        inOvlHw,    // input overload from hardware path
    input  wire [11:0] powerOut,   // output power, watts
    input  wire [7:0]  currentOut, // output current, amperes
    output reg         paActive,   // final amp active (not bypass)
    output reg         readyLed,   // ready indicator
    output reg         filterEn,   // filter board control enable
    output reg         intPtt,     // internal ptt to final amp
    output reg         manualLed,  // manual tune indicator
    output reg         meterTune,  // meter in 250 W tuning view
    output reg  [3:0]  dispMsg,    // display message code
    output reg  [7:0]  lOut,       // output inductance step
    output reg  [7:0]  cOut,       // output capacitance step
    output reg  [7:0]  ccOut,      // center capacitance setting step
    output reg         saveStb     // persistent store strobe
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    reg [2:0] syncA_ff;            // first stage
    reg [2:0] syncB_ff;            // second stage, only this is read
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            syncA_ff <= 3'h0;
            syncB_ff <= 3'h0;
        end else begin
            syncA_ff <= {inOvlHw, inOvlSw, trxPtt};
            syncB_ff <= syncA_ff;
        end
    end
    wire pttS   = syncB_ff[0];     // synced transceiver ptt
    wire ovlSwS = syncB_ff[1];     // synced software input overload
    wire ovlHwS = syncB_ff[2];     // synced hardware input overload

    // power and current come from an on-chip converter on this clock
    wire overWin  = powerOut > `APT_WIN_HIGH_W;
    wire underWin = powerOut < `APT_WIN_LOW_W;
    wire overTune = powerOut > `APT_TUNE_MAX_W;
    wire overLow  = powerOut > `APT_OVL_LOW_W;
    wire overMid  = powerOut > `APT_OVL_MID_W;
    wire overHigh = powerOut > `APT_OVL_HIGH_W;
    wire overCur  = currentOut > `APT_OVL_CUR_A;

    // ------------------------------------------------------------------
    // apb slave: zero-wait, single-cycle access phase
    // ------------------------------------------------------------------
    wire apbAcc = psel & penable;
    wire apbWr  = apbAcc & pwrite;
    wire mapped = (paddr == `APT_OFS_CTRL) || (paddr == `APT_OFS_STATUS) ||
                  (paddr == `APT_OFS_POWER) || (paddr == `APT_OFS_FILTER) ||
                  (paddr == `APT_OFS_BAND) || (paddr == `APT_OFS_TUNED);
    wire ctrlWr = apbWr & (paddr == `APT_OFS_CTRL);
    // button presses arrive as write-one pulses in the control word
    wire pOper  = ctrlWr & pwdata[`APT_CTRL_OPERATE];
    wire pMan   = ctrlWr & pwdata[`APT_CTRL_MANUAL];
    wire pAuto  = ctrlWr & pwdata[`APT_CTRL_AUTO];
    wire pLdn   = ctrlWr & pwdata[`APT_CTRL_LDN];
    wire pLup   = ctrlWr & pwdata[`APT_CTRL_LUP];
    wire pCdn   = ctrlWr & pwdata[`APT_CTRL_CDN];
    wire pCup   = ctrlWr & pwdata[`APT_CTRL_CUP];
    wire pCCdn  = ctrlWr & pwdata[`APT_CTRL_CCDN];
    wire pCCup  = ctrlWr & pwdata[`APT_CTRL_CCUP];
    wire pMenu  = ctrlWr & pwdata[`APT_CTRL_MENU];

    reg [5:0]  band_ff;            // current subband index
    reg        autoMode_ff;        // auto tuning selected (mode flag only)
    reg        menuOpen_ff;        // softkey menu shown
    reg        tripped_ff;         // overload trip latched
    reg [4:0]  ovlFlags_ff;        // sticky: insw inhw low mid high/cur
    reg [SUBBANDS-1:0] tuned_ff;   // subband tuned marks
    reg [23:0] store_ff [0:SUBBANDS-1]; // per-subband settings

    // ------------------------------------------------------------------
    // operate interlock
    // ------------------------------------------------------------------
    wire tuning  = manualLed | autoMode_ff;
    wire goActive = pOper & ~paActive & ~pttS;
    wire goBypass = pOper & paActive & ~tuning;
    wire hardOff  = overHigh & paActive;
    // the 1500 W trip outranks any button press
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            paActive <= 1'b0;
            readyLed <= 1'b0;
            filterEn <= 1'b0;
        end else if (hardOff) begin
            paActive <= 1'b0;
            readyLed <= 1'b0;
            filterEn <= 1'b0;
        end else if (goActive | goBypass) begin
            paActive <= goActive;
            readyLed <= goActive;
            filterEn <= goActive;
        end
    end

    // ------------------------------------------------------------------
    // tuning modes, menu, subband register
    // ------------------------------------------------------------------
    reg pttSeen_ff;                // ptt was on during this tuning
    wire manOn    = pMan & ~manualLed & paActive & ~autoMode_ff;
    wire manBtnEnd = pMan & manualLed;
    wire manAbort = manualLed & overTune;
    wire manPttEnd = manualLed & pttSeen_ff & ~pttS;
    wire manEnd   = manBtnEnd | manPttEnd;
    // tune mode, auto flag, menu and subband select
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            manualLed   <= 1'b0;
            meterTune   <= 1'b0;
            autoMode_ff <= 1'b0;
            menuOpen_ff <= 1'b0;
            pttSeen_ff  <= 1'b0;
            band_ff     <= 6'h00;
        end else begin
            if (manOn) begin
                manualLed <= 1'b1;
                meterTune <= 1'b1;
            end else if (manAbort | manEnd) begin
                manualLed <= 1'b0;
                meterTune <= autoMode_ff;
            end
            // auto tuning engine lives elsewhere; only its mode flag is kept
            if (pAuto & ~manualLed)
                autoMode_ff <= ~autoMode_ff & paActive;
            if (manualLed & pttS)
                pttSeen_ff <= 1'b1;
            else if (~manualLed)
                pttSeen_ff <= 1'b0;
            // menu is refused while manual tuning, and hidden on entry
            if (manOn)
                menuOpen_ff <= 1'b0;
            else if (pMenu & ~manualLed)
                menuOpen_ff <= ~menuOpen_ff;
            if (apbWr & (paddr == `APT_OFS_BAND) & ~manualLed)
                band_ff <= pwdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // filter elements: load from store, step while power is in window
    // ------------------------------------------------------------------
    wire inWin = manualLed & ~underWin & ~overWin;

    function [7:0] stepVal;
        input [7:0] v;
        input       dn;
        input       up;
        begin
            if (up & ~dn & (v != `APT_STEP_MAX))
                stepVal = v + 8'h01;
            else if (dn & ~up & (v != 8'h00))
                stepVal = v - 8'h01;
            else
                stepVal = v;
        end
    endfunction
    wire [23:0] stored = store_ff[band_ff];
    // manual tune entry loads the slot; steps only in window
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lOut  <= `APT_STEP_RST;
            cOut  <= `APT_STEP_RST;
            ccOut <= `APT_STEP_RST;
        end else if (manOn) begin
            {lOut, cOut, ccOut} <= stored;
        end else if (inWin) begin
            lOut  <= stepVal(lOut, pLdn, pLup);
            cOut  <= stepVal(cOut, pCdn, pCup);
            ccOut <= stepVal(ccOut, pCCdn, pCCup);
        end
    end

    // persistent store: the array stands in for the nonvolatile part
    genvar gi;
    generate
        for (gi = 0; gi < SUBBANDS; gi = gi + 1) begin : gSlot
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    store_ff[gi] <= {`APT_STEP_RST, `APT_STEP_RST, `APT_STEP_RST};
                    tuned_ff[gi] <= 1'b0;
                end else if (manEnd & (band_ff == gi)) begin
                    store_ff[gi] <= {lOut, cOut, ccOut};
                    tuned_ff[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            saveStb <= 1'b0;
        else
            saveStb <= manEnd;
    end

    // ------------------------------------------------------------------
    // overload timers and trip
    // ------------------------------------------------------------------
    reg [31:0] lowCnt_ff;          // time above 1050 W
    reg [31:0] midCnt_ff;          // time above 1300 W
    reg [31:0] curCnt_ff;          // time above 42 A
    reg [31:0] errCnt_ff;          // error message hold
    wire lowHit = overLow & (lowCnt_ff >= LOW_CYC);
    wire midHit = overMid & (midCnt_ff >= MID_CYC);
    wire curHit = overCur & (curCnt_ff >= CUR_CYC);
    wire anyOvl = ovlSwS | ovlHwS | lowHit | midHit | overHigh | curHit;

    // first matching source names the error
    reg [3:0] ovlMsg;
    always @* begin
        ovlMsg = `APT_MSG_NONE;
        if (overHigh)
            ovlMsg = `APT_MSG_OUTHIGH;
        else if (ovlHwS)
            ovlMsg = `APT_MSG_INOVL1;
        else if (ovlSwS)
            ovlMsg = `APT_MSG_INOVL;
        else if (midHit)
            ovlMsg = `APT_MSG_OUTMID;
        else if (lowHit)
            ovlMsg = `APT_MSG_OUTOVL;
        else if (curHit)
            ovlMsg = `APT_MSG_CUROVL;
    end
    reg [3:0] errMsg_ff;           // latched error message
    // counters saturate at the limit instead of wrapping
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lowCnt_ff   <= 32'h0;
            midCnt_ff   <= 32'h0;
            curCnt_ff   <= 32'h0;
            errCnt_ff   <= 32'h0;
            errMsg_ff   <= `APT_MSG_NONE;
            tripped_ff  <= 1'b0;
            ovlFlags_ff <= 5'h00;
        end else begin
            lowCnt_ff <= overLow ? lowCnt_ff + ((lowCnt_ff < LOW_CYC) ? 32'h1 : 32'h0) : 32'h0;
            midCnt_ff <= overMid ? midCnt_ff + ((midCnt_ff < MID_CYC) ? 32'h1 : 32'h0) : 32'h0;
            curCnt_ff <= overCur ? curCnt_ff + ((curCnt_ff < CUR_CYC) ? 32'h1 : 32'h0) : 32'h0;
            if (anyOvl & ~tripped_ff) begin
                tripped_ff <= 1'b1;
                errCnt_ff  <= ERR_CYC;
                errMsg_ff  <= ovlMsg;
            end else begin
                if (tripped_ff & ~pttS & ~anyOvl)
                    tripped_ff <= 1'b0;
                if (errCnt_ff != 32'h0)
                    errCnt_ff <= errCnt_ff - 32'h1;
            end
            // sticky flags, set wins over a clear in the same write
            ovlFlags_ff <= (ovlFlags_ff &
                ~((apbWr & (paddr == `APT_OFS_STATUS)) ? pwdata[12:8] : 5'h00)) |
                {overHigh | curHit, midHit, lowHit, ovlHwS, ovlSwS};
        end
    end

    // internal ptt and display
    reg [3:0] nxt_msg;
    always @* begin
        if (errCnt_ff != 32'h0)
            nxt_msg = errMsg_ff;
        else if (manAbort)
            nxt_msg = `APT_MSG_ABORT;
        else if (manBtnEnd)
            nxt_msg = `APT_MSG_DONE;
        else if (manualLed & ~pttS)
            nxt_msg = `APT_MSG_SETPTT;
        else if (manualLed & underWin)
            nxt_msg = `APT_MSG_SIGLOW;
        else if (manualLed & overWin)
            nxt_msg = `APT_MSG_SIGHIGH;
        else if (manualLed)
            nxt_msg = `APT_MSG_PLTUNE;
        else if ((dispMsg == `APT_MSG_DONE) | (dispMsg == `APT_MSG_ABORT))
            nxt_msg = pttS ? dispMsg : `APT_MSG_NONE;   // stays until ptt released
        else
            nxt_msg = `APT_MSG_NONE;
    end
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intPtt  <= 1'b0;
            dispMsg <= `APT_MSG_NONE;
        end else begin
            intPtt  <= paActive & pttS & ~tripped_ff & ~anyOvl & ~hardOff;
            dispMsg <= nxt_msg;
        end
    end

    // tuned marks of the low 32 slots; spare bits read as zero
    wire [31:0] tunedWord;         // tuned marks as one word
    genvar gt;
    generate
        for (gt = 0; gt < 32; gt = gt + 1) begin : gTun
            if (gt < SUBBANDS) begin : gUse
                assign tunedWord[gt] = tuned_ff[gt];
            end else begin : gZero
                assign tunedWord[gt] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;   // ready in first access cycle
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= 32'h0;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    `APT_OFS_STATUS: prdata <= {18'h0, ovlFlags_ff, dispMsg, menuOpen_ff,
                        tripped_ff, autoMode_ff, manualLed, paActive};
                    `APT_OFS_POWER:  prdata <= {12'h0, currentOut, powerOut};
                    `APT_OFS_FILTER: prdata <= {8'h0, lOut, cOut, ccOut};
                    `APT_OFS_BAND:   prdata <= {25'h0, tuned_ff[band_ff], band_ff};
                    `APT_OFS_TUNED:  prdata <= tunedWord;
                    default:         prdata <= 32'h0;
                endcase
            end
        end
    end

endmodule // apt_amp_ctrl

// [dv/apt_chk.sv]
`timescale 1ns/1ps
`include "apt_defines.vh"
// ------------------------------------------------------------
// interlock and protection checker
// ------------------------------------------------------------
module apt_chk #(
    parameter integer LOW_CYC = 20, // 1050 W persistence
    parameter integer MID_CYC = 10  // 1300 W persistence
) (
    input wire        clk_sys,   // system clock
    input wire        rst,       // async reset
    input wire [11:0] powerOut,  // output power
    input wire        paActive,  // amp active
    input wire        readyLed,  // ready lamp
    input wire        filterEn,  // filter control
    input wire        intPtt,    // internal ptt
    input wire        manualLed, // tune lamp
    input wire        meterTune, // tuning meter
    input wire [3:0]  dispMsg,   // display code
    input wire [7:0]  lOut       // inductance step
);
    logic [7:0] lowCnt_ff; // cycles in 1050..1300 W band
    logic [7:0] midCnt_ff; // cycles in 1300..1500 W band
    logic       inLow;     // power in low overload band
    logic       inMid;     // power in mid overload band
    assign inLow = powerOut > `APT_OVL_LOW_W && powerOut <= `APT_OVL_MID_W;
    assign inMid = powerOut > `APT_OVL_MID_W && powerOut <= `APT_OVL_HIGH_W;
    // saturating run counters; leaving the band restarts them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lowCnt_ff <= 8'h00;
            midCnt_ff <= 8'h00;
        end else begin
            lowCnt_ff <= inLow ? lowCnt_ff + {7'h00, ~&lowCnt_ff} : 8'h00;
            midCnt_ff <= inMid ? midCnt_ff + {7'h00, ~&midCnt_ff} : 8'h00;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_ACTIVE: assert property (paActive |-> readyLed && filterEn)
        else $error("active amp without ready lamp or filter control");
    AST_BYPASS: assert property (!paActive |-> !readyLed && !filterEn)
        else $error("bypass with ready lamp or filter control on");
    AST_TUNE_PA: assert property (manualLed |-> paActive)
        else $error("manual tuning while amp in bypass");
    AST_METER: assert property (manualLed |-> meterTune)
        else $error("manual tuning without tuning meter view");
    AST_PTT: assert property (intPtt |-> $past(paActive))
        else $error("internal ptt while amp not active");
    AST_HIGH: assert property (powerOut > `APT_OVL_HIGH_W |-> ##[1:4] !paActive)
        else $error("amp not shut off above 1500 W");
    AST_ABORT: assert property (manualLed && powerOut > `APT_TUNE_MAX_W
        |-> ##[1:4] !manualLed)
        else $error("tuning not aborted above 250 W");
    AST_LSTEP: assert property (manualLed && $past(manualLed) && lOut != $past(lOut)
        |-> lOut == $past(lOut) + 8'h01 || lOut == $past(lOut) - 8'h01)
        else $error("inductance moved by more than one step");
    AST_LOW: assert property (lowCnt_ff == LOW_CYC + 4
        |-> dispMsg == `APT_MSG_OUTOVL && !intPtt)
        else $error("low output overload not flagged");
    AST_MID: assert property (midCnt_ff == MID_CYC + 4 |-> dispMsg == `APT_MSG_OUTMID)
        else $error("mid output overload not flagged");
endmodule // apt_chk

bind apt_amp_ctrl apt_chk #(.LOW_CYC(LOW_CYC), .MID_CYC(MID_CYC)) u_chk (
    .clk_sys, .rst, .powerOut, .paActive, .readyLed, .filterEn,
    .intPtt, .manualLed, .meterTune, .dispMsg, .lOut
);

// [dv/apt_trx_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// transceiver stand-in: keyed ptt and the drive it yields
// ------------------------------------------------------------
module apt_trx_model (
    input  wire         clk_sys,   // system clock
    input  wire         keyOn,     // operator keys transmitter
    input  wire  [11:0] fwdW,      // power the drive produces
    input  wire  [7:0]  curA,      // current that drive draws
    output logic        trxPtt,    // ptt line to amplifier
    output logic [11:0] powerOut,  // sensed output power
    output logic [7:0]  currentOut // sensed output current
);
    initial begin
        trxPtt = 1'b0;
        powerOut = 12'h000;
        currentOut = 8'h00;
    end
    // ptt held unbroken while keyed; unkeyed means no drive at all
    always @(posedge clk_sys) begin
        trxPtt     <= keyOn;
        powerOut   <= keyOn ? fwdW : 12'h000;
        currentOut <= keyOn ? curA : 8'h00;
    end
endmodule // apt_trx_model

// [dv/tb.sv]
`timescale 1ns/1ps
`include "apt_defines.vh"
module tb;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, fwdW = 12'h000, powerOut;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, trxPtt, keyOn = 1'b0, inOvlSw = 1'b0, inOvlHw = 1'b0;
    logic [7:0] curA = 8'h00, currentOut, lOut, cOut, ccOut, expL;
    logic paActive, readyLed, filterEn, intPtt, manualLed, meterTune, saveStb;
    logic [3:0] dispMsg;
    int mismatches = 0, cmpCount = 0, cycles = 0, saves = 0, i;
    // tuning window rows: power, display, whether a step is taken
    localparam logic [11:0] WP [7] = '{12'h01E, 12'h03B, 12'h03C, 12'h050, 12'h064, 12'h065,
        12'h0C8};
    localparam logic [3:0] WM [7] = '{`APT_MSG_SIGLOW, `APT_MSG_SIGLOW, `APT_MSG_PLTUNE,
        `APT_MSG_PLTUNE, `APT_MSG_PLTUNE, `APT_MSG_SIGHIGH, `APT_MSG_SIGHIGH};
    localparam logic [6:0] WD = 7'b0011100;
    // element step buttons and the {L,C,CC} they should leave
    localparam int SB [5] = '{3, 6, 5, 8, 7};
    localparam logic [23:0] SX [5] = '{24'h828080, 24'h828180, 24'h828080, 24'h828081, 24'h828080};
    // overload rows: power, current, sw, hw, wait, display
    localparam logic [11:0] OP [6] = '{12'h44C, 12'h578, 12'h640, 12'h050, 12'h050, 12'h050};
    localparam logic [7:0] OC [6] = '{8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00};
    localparam logic [5:0] OS = 6'b010000;
    localparam logic [5:0] OH = 6'b100000;
    localparam int OW [6] = '{26, 16, 6, 46, 6, 6};
    localparam logic [3:0] OM [6] = '{`APT_MSG_OUTOVL, `APT_MSG_OUTMID, `APT_MSG_OUTHIGH,
        `APT_MSG_CUROVL, `APT_MSG_INOVL, `APT_MSG_INOVL1};
    always #12.5 clk_sys = ~clk_sys;
    // short counts keep overload timers within a brief run
    apt_amp_ctrl #(.LOW_CYC(20), .MID_CYC(10), .CUR_CYC(40), .ERR_CYC(30)) u_dut (
        .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .trxPtt, .inOvlSw, .inOvlHw, .powerOut, .currentOut, .paActive,
        .readyLed, .filterEn, .intPtt, .manualLed, .meterTune, .dispMsg, .lOut, .cOut,
        .ccOut, .saveStb);
    apt_trx_model u_trx (.clk_sys, .keyOn, .fwdW, .curA, .trxPtt, .powerOut, .currentOut);
    task automatic stopTest();
        $display("mismatches %0d comparisons %0d", mismatches, cmpCount);
        if (mismatches == 0 && cmpCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmpCount++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one apb transfer; request held until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        chk(n < 16, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic press(input int b);
        apb(1'b1, `APT_OFS_CTRL, 32'h0000_0001 << b);
        wt(3);
    endtask
    // cycle ceiling; a hang counts against the run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stopTest();
        end
    end
    always @(posedge clk_sys) if (saveStb === 1'b1) saves++;
    initial begin
        wt(10);
        rst <= 1'b0;
        wt(1);
        chk({paActive, readyLed, filterEn, lOut}, {3'b000, 8'h80});
        apb(1'b0, 12'hFFC, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        press(1);
        chk({manualLed, meterTune}, 2'b00);
        keyOn <= 1'b1;
        wt(4);
        press(0);
        chk(paActive, 1'b0);
        keyOn <= 1'b0;
        wt(4);
        press(0);
        chk({paActive, readyLed, filterEn}, 3'b111);
        press(1);
        chk({manualLed, meterTune}, 2'b11);
        press(9);
        apb(1'b0, `APT_OFS_STATUS, 32'h0);
        chk(rd[4], 1'b0);
        press(0);
        chk(paActive, 1'b1);
        keyOn <= 1'b1;
        expL = 8'h80;
        for (i = 0; i < 7; i++) begin
            fwdW <= WP[i];
            wt(6);
            chk({dispMsg, intPtt}, {WM[i], 1'b1});
            press(4);
            expL = expL + {7'h00, WD[i]};
            chk(lOut, expL);
        end
        fwdW <= 12'h050;
        wt(4);
        for (i = 0; i < 5; i++) begin
            press(SB[i]);
            chk({lOut, cOut, ccOut}, SX[i]);
        end
        press(1);
        chk({manualLed, dispMsg, saves[7:0]}, {1'b0, `APT_MSG_DONE, 8'h01});
        apb(1'b0, `APT_OFS_TUNED, 32'h0);
        chk(rd[0], 1'b1);
        press(1);
        keyOn <= 1'b0;
        wt(6);
        chk({manualLed, saves[7:0]}, {1'b0, 8'h02});
        press(1);
        fwdW <= 12'h12C;
        keyOn <= 1'b1;
        wt(6);
        chk(manualLed, 1'b0);
        keyOn <= 1'b0;
        wt(6);
        press(2);
        press(0);
        apb(1'b0, `APT_OFS_STATUS, 32'h0);
        chk({rd[2], paActive}, 2'b11);
        press(2);
        press(0);
        chk({paActive, readyLed, filterEn}, 3'b000);
        for (i = 0; i < 6; i++) begin
            if (paActive !== 1'b1) press(0);
            fwdW <= OP[i];
            curA <= OC[i];
            inOvlSw <= OS[i];
            inOvlHw <= OH[i];
            keyOn <= 1'b1;
            wt(OW[i]);
            chk({dispMsg, intPtt}, {OM[i], 1'b0});
            if (i == 2) chk(paActive, 1'b0);
            keyOn <= 1'b0;
            inOvlSw <= 1'b0;
            inOvlHw <= 1'b0;
            wt(40);
            apb(1'b0, `APT_OFS_STATUS, 32'h0);
            chk({rd[3], dispMsg}, {1'b0, `APT_MSG_NONE});
        end
        stopTest();
    end
endmodule // tb
